// File: bench/edge_timestamp_latch_status_tb_top.sv
// self-checking bench for the edge timestamp latch
`timescale 1ns/1ps
`default_nettype none
module edge_timestamp_latch_status_tb_top;
    import etls_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] pin = 4'h0;
    logic [3:0] mode = 4'hf;
    logic [3:0] req = 4'h0;
    logic [3:0] rd;
    logic [63:0] t = 64'h0000_0000_0000_0100;
    logic [3:0][63:0] ts;
    logic [3:0][7:0] sb;
    logic [63:0] tt;
    logic [63:0] t1;
    int error_cnt = 0;
    int checks = 0;
    // clock and system time, time moved on the falling edge
    always #25 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i) t <= t + 64'h1;
    etls_latch #(.NCH(4), .TS_W(64)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .chan_in_i(pin), .sys_time_i(t),
        .mode_first_edge_i(mode), .ts_read_i(rd), .edge_timestamp_value_o(ts),
        .channel_edge_status_byte_o(sb)
    );
    etls_master_model mst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req), .ts_read_o(rd));
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // set one pin, return time at the capture edge, wait past capture
    task automatic drive(input int c, input logic v, output logic [63:0] x);
        @(negedge clk_sys_i);
        pin[c] <= v;
        #1 x = t + 64'h2;
        repeat (3) @(negedge clk_sys_i);
    endtask : drive
    // master read of the masked channels
    task automatic rdm(input logic [3:0] m);
        @(negedge clk_sys_i);
        req <= m;
        @(negedge clk_sys_i);
        req <= 4'h0;
        repeat (2) @(negedge clk_sys_i);
    endtask : rdm
    // first-edge mode on channel 0
    task automatic s_first();
        drive(0, 1'b1, tt);
        chk("sb0 rise", 64'h01, 64'(sb[0]));
        chk("ts0 rise", tt, ts[0]);
        chk("sb1 idle", 64'h00, 64'(sb[1]));
        drive(0, 1'b0, t1);
        repeat (5) @(negedge clk_sys_i);
        chk("sb0 held", 64'h01, 64'(sb[0]));
        chk("ts0 held", tt, ts[0]);
        rdm(4'h1);
        chk("sb0 read", 64'h00, 64'(sb[0]));
        drive(0, 1'b1, tt);
        rdm(4'h1);
        drive(0, 1'b0, tt);
        chk("sb0 fall", 64'h02, 64'(sb[0]));
        chk("ts0 fall", tt, ts[0]);
    endtask : s_first
    // last-edge mode on channel 2, switch into last-edge mode on channel 3
    task automatic s_cont();
        @(negedge clk_sys_i);
        mode[2] <= 1'b0;
        drive(2, 1'b1, tt);
        chk("ts2 rise", tt, ts[2]);
        chk("sb2 rise", 64'h00, 64'(sb[2]));
        drive(2, 1'b0, tt);
        chk("ts2 fall", tt, ts[2]);
        chk("sb2 fall", 64'h00, 64'(sb[2]));
        rdm(4'h4);
        drive(2, 1'b1, tt);
        chk("ts2 again", tt, ts[2]);
        chk("sb2 rsv", 64'h00, 64'(sb[2]));
        drive(3, 1'b1, tt);
        chk("sb3 rise", 64'h01, 64'(sb[3]));
        mode[3] <= 1'b0;
        @(negedge clk_sys_i);
        chk("sb3 mode switch", 64'h00, 64'(sb[3]));
        mode[3] <= 1'b1;
        drive(3, 1'b0, t1);
        chk("sb3 freed", 64'h02, 64'(sb[3]));
        chk("ts3 freed", t1, ts[3]);
    endtask : s_cont
    // edge captured in the very cycle of a read on channel 1: the edge wins
    task automatic s_set_wins();
        drive(1, 1'b1, tt);
        chk("sb1 rise", 64'h01, 64'(sb[1]));
        @(negedge clk_sys_i);
        pin[1] <= 1'b0;
        #1 t1 = t + 64'h2;
        @(negedge clk_sys_i);
        req <= 4'h2;
        @(negedge clk_sys_i);
        req <= 4'h0;
        repeat (2) @(negedge clk_sys_i);
        chk("sb1 set wins", 64'h02, 64'(sb[1]));
        chk("ts1 set wins", t1, ts[1]);
        rdm(4'h2);
        chk("sb1 read", 64'h00, 64'(sb[1]));
        drive(1, 1'b1, tt);
        chk("ts1 after read", tt, ts[1]);
    endtask : s_set_wins
    // reset in mid-run with pins 1 and 2 held high across the release
    task automatic s_reset();
        @(negedge clk_sys_i);
        rst_n_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("ts2 in reset", 64'h0, ts[2]);
        chk("sb1 in reset", 64'h00, 64'(sb[1]));
        @(negedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1 tt = t + 64'h2;
        @(negedge clk_sys_i);
        chk("sb1 after reset", 64'h00, 64'(sb[1]));
        chk("ts1 after reset", 64'h0, ts[1]);
        repeat (2) @(negedge clk_sys_i);
        chk("sb1 high at reset", 64'h01, 64'(sb[1]));
        chk("ts1 high at reset", tt, ts[1]);
        chk("ts2 high at reset", tt, ts[2]);
        chk("sb2 high at reset", 64'h00, 64'(sb[2]));
    endtask : s_reset
    task automatic test_done();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // main sequence
    initial begin
        repeat (20) @(negedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        s_first();
        s_set_wins();
        s_cont();
        s_reset();
        test_done();
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        error_cnt++;
        test_done();
    end
endmodule : edge_timestamp_latch_status_tb_top
`default_nettype wire

// File: bench/etls_master_model.sv
// fieldbus master model: issues one-cycle timestamp read strobes
`timescale 1ns/1ps
`default_nettype none
module etls_master_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [3:0] req_i,
    output logic [3:0] ts_read_o
);
    logic [3:0] req_q;
    // take the bench request on the rising edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q <= 4'h0;
        end else begin
            req_q <= req_i;
        end
    end
    // read strobe launched off the falling edge, one cycle wide
    always_ff @(negedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ts_read_o <= 4'h0;
        end else begin
            ts_read_o <= req_q;
        end
    end
endmodule : etls_master_model
`default_nettype wire

// File: design/etls_latch.sv
// per-channel edge timestamp latch with edge status bytes
// Function
// - last-edge mode: every input change overwrites the stored timestamp, reads ignored
// - last-edge mode: no edge flags are set in the status byte
// - status bits one and zero report a latched falling or rising edge
// - status bit zero flags a captured rising edge
// - status bits seven to two reserved, read zero, reader ignores them
// - edge flags are raised only in first-edge mode
// - a set flag stays until the timestamp is read or the channel goes to last-edge mode; the read clears it unless an edge is captured in the same cycle
// - only one edge event with its timestamp is held per channel per cycle
// - first-edge mode: first change after a read is kept until the next read
`timescale 1ns/1ps
`default_nettype none
module etls_latch #(
    parameter int unsigned NCH = etls_pkg::ETLS_NCH_DEF,
    parameter int unsigned TS_W = etls_pkg::ETLS_TS_W_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [NCH-1:0] chan_in_i,
    input wire logic [TS_W-1:0] sys_time_i,
    input wire logic [NCH-1:0] mode_first_edge_i,
    input wire logic [NCH-1:0] ts_read_i,
    output logic [NCH-1:0][TS_W-1:0] edge_timestamp_value_o,
    output logic [NCH-1:0][etls_pkg::ETLS_SB_W-1:0] channel_edge_status_byte_o
);
    import etls_pkg::*;

    // rising edge of a synchronised level against its previous sample
    function automatic logic f_rise(input logic now_v, input logic prev_v);
        f_rise = now_v & ~prev_v;
    endfunction : f_rise

    // falling edge of a synchronised level against its previous sample
    function automatic logic f_fall(input logic now_v, input logic prev_v);
        f_fall = ~now_v & prev_v;
    endfunction : f_fall

    logic [NCH-1:0] chan_sync;
    logic [NCH-1:0] prev_d;
    logic [NCH-1:0] prev_q;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;
    logic [NCH-1:0][TS_W-1:0] ts_d;
    logic [NCH-1:0][TS_W-1:0] ts_q;
    logic [NCH-1:0] flag_rise_d;
    logic [NCH-1:0] flag_rise_q;
    logic [NCH-1:0] flag_fall_d;
    logic [NCH-1:0] flag_fall_q;
    etls_hold_t hold_d [NCH];
    etls_hold_t hold_q [NCH];

    // input pins pass two flops before any edge logic
    etls_sync #(
        .W(NCH)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(chan_in_i),
        .sync_o(chan_sync)
    );

    // edge detection on the synchronised levels
    always_comb begin
        prev_d = chan_sync;
        for (int c = 0; c < NCH; c++) begin
            rise[c] = f_rise(chan_sync[c], prev_q[c]);
            fall[c] = f_fall(chan_sync[c], prev_q[c]);
        end
    end

    // next latch state per channel
    always_comb begin
        ts_d = ts_q;
        flag_rise_d = flag_rise_q;
        flag_fall_d = flag_fall_q;
        for (int c = 0; c < NCH; c++) begin
            hold_d[c] = hold_q[c];
            if (mode_first_edge_i[c]) begin
                // single event: capture only when free or released this cycle
                if ((rise[c] || fall[c]) && (hold_q[c] == ETLS_HOLD_FREE || ts_read_i[c])) begin
                    ts_d[c] = sys_time_i;
                    flag_rise_d[c] = rise[c];
                    flag_fall_d[c] = fall[c];
                    hold_d[c] = ETLS_HOLD_FULL;
                end else if (ts_read_i[c]) begin
                    // read releases the latch and clears both flags
                    flag_rise_d[c] = 1'b0;
                    flag_fall_d[c] = 1'b0;
                    hold_d[c] = ETLS_HOLD_FREE;
                end
            end else begin
                // continuous: latest edge wins, no flags, reads ignored
                if (rise[c] || fall[c]) begin
                    ts_d[c] = sys_time_i;
                end
                flag_rise_d[c] = 1'b0;
                flag_fall_d[c] = 1'b0;
                hold_d[c] = ETLS_HOLD_FREE;
            end
        end
    end

    // register the latch state
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= '0;
            flag_rise_q <= '0;
            flag_fall_q <= '0;
            for (int c = 0; c < NCH; c++) begin
                ts_q[c] <= TS_W'(ETLS_TS_RESET);
                hold_q[c] <= ETLS_HOLD_FREE;
            end
        end else begin
            prev_q <= prev_d;
            ts_q <= ts_d;
            flag_rise_q <= flag_rise_d;
            flag_fall_q <= flag_fall_d;
            for (int c = 0; c < NCH; c++) begin
                hold_q[c] <= hold_d[c];
            end
        end
    end

    // output assembly: timestamps and status bytes
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            edge_timestamp_value_o[c] = ts_q[c];
            channel_edge_status_byte_o[c] = ETLS_SB_RESET;
            channel_edge_status_byte_o[c][ETLS_SB_RISE_BIT] = flag_rise_q[c];
            channel_edge_status_byte_o[c][ETLS_SB_FALL_BIT] = flag_fall_q[c];
            channel_edge_status_byte_o[c][ETLS_SB_W-1:ETLS_SB_RSV_LO] = ETLS_SB_RSV_VAL;
        end
    end

    // per-channel checks on the latch behaviour
    for (genvar g = 0; g < NCH; g++) begin : g_chk
        logic edge_v;
        logic free_v;
        assign edge_v = rise[g] | fall[g];
        assign free_v = (hold_q[g] == ETLS_HOLD_FREE) | ts_read_i[g];

        a_last_edge_update: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            (!mode_first_edge_i[g] && edge_v) |=> (ts_q[g] == $past(sys_time_i)))
            else $error("continuous mode missed a timestamp update");

        a_last_no_flags: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            !mode_first_edge_i[g] |=> (channel_edge_status_byte_o[g][ETLS_SB_FALL_BIT:ETLS_SB_RISE_BIT] == 2'b00))
            else $error("edge flag set in continuous mode");

        a_flag_means_held: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            (flag_rise_q[g] || flag_fall_q[g]) |-> (hold_q[g] == ETLS_HOLD_FULL))
            else $error("edge flag without a held event");

        a_rise_flag_set: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            (mode_first_edge_i[g] && rise[g] && free_v)
            |=> (channel_edge_status_byte_o[g][ETLS_SB_RISE_BIT] && !flag_fall_q[g]
                 && ts_q[g] == $past(sys_time_i)))
            else $error("rising edge not latched");

        a_fall_flag_set: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            (mode_first_edge_i[g] && fall[g] && free_v)
            |=> (channel_edge_status_byte_o[g][ETLS_SB_FALL_BIT] && !flag_rise_q[g]
                 && ts_q[g] == $past(sys_time_i)))
            else $error("falling edge not latched");

        a_reserved_zero: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            channel_edge_status_byte_o[g][ETLS_SB_W-1:ETLS_SB_RSV_LO] == ETLS_SB_RSV_VAL)
            else $error("reserved status bits not zero");

        a_flag_only_single: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            ($rose(flag_rise_q[g]) || $rose(flag_fall_q[g])) |-> $past(mode_first_edge_i[g]))
            else $error("edge flag raised outside first-edge mode");

        a_flag_held: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            ((flag_rise_q[g] || flag_fall_q[g]) && mode_first_edge_i[g] && !ts_read_i[g])
            |=> $stable(flag_rise_q[g]) && $stable(flag_fall_q[g]))
            else $error("edge flag dropped without a read");

        a_read_clears: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            (mode_first_edge_i[g] && ts_read_i[g] && !edge_v)
            |=> (!flag_rise_q[g] && !flag_fall_q[g] && hold_q[g] == ETLS_HOLD_FREE))
            else $error("read did not release the latch");

        a_one_event: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            !(flag_rise_q[g] && flag_fall_q[g]))
            else $error("two edge events held at once");

        a_first_kept: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            (mode_first_edge_i[g] && hold_q[g] == ETLS_HOLD_FULL && !ts_read_i[g])
            |=> $stable(ts_q[g]) [*1])
            else $error("held first-edge timestamp overwritten");

        a_set_wins_read: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            (mode_first_edge_i[g] && ts_read_i[g] && edge_v)
            |=> (hold_q[g] == ETLS_HOLD_FULL && flag_rise_q[g] == $past(rise[g])
                 && flag_fall_q[g] == $past(fall[g])))
            else $error("edge in a read cycle was not captured");

        a_cont_read_ignored: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            (!mode_first_edge_i[g] && ts_read_i[g] && !edge_v) |=> $stable(ts_q[g]))
            else $error("read changed a continuous-mode timestamp");

        a_cont_frees_latch: assert property (
            @(posedge clk_sys_i) disable iff (!rst_n_i)
            !mode_first_edge_i[g] |=> (hold_q[g] == ETLS_HOLD_FREE))
            else $error("latch still held in continuous mode");
    end
endmodule : etls_latch
`default_nettype wire

// File: design/etls_pkg.sv
// constants and types shared by the edge timestamp latch files
package etls_pkg;
    // default channel count and timestamp width
    localparam int unsigned ETLS_NCH_DEF = 4;
    localparam int unsigned ETLS_TS_W_DEF = 64;
    // status byte layout
    localparam int unsigned ETLS_SB_W = 8;
    localparam int unsigned ETLS_SB_RISE_BIT = 0;
    localparam int unsigned ETLS_SB_FALL_BIT = 1;
    localparam int unsigned ETLS_SB_RSV_LO = 2;
    localparam logic [7:0] ETLS_SB_RESET = 8'h00;
    localparam logic [5:0] ETLS_SB_RSV_VAL = 6'h00;
    // timestamp reset value
    localparam logic [63:0] ETLS_TS_RESET = 64'h0000_0000_0000_0000;
    // synchroniser depth
    localparam int unsigned ETLS_SYNC_STAGES = 2;
    // per-channel hold state of the first-edge latch
    typedef enum logic {
        ETLS_HOLD_FREE,
        ETLS_HOLD_FULL
    } etls_hold_t;
endpackage : etls_pkg

// File: design/etls_sync.sv
// two-flop synchroniser for the channel input pins
`timescale 1ns/1ps
`default_nettype none
module etls_sync #(
    parameter int unsigned W = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    import etls_pkg::*;

    logic [W-1:0] meta_d;
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_d;
    logic [W-1:0] sync_q;

    // next values: first stage feeds only the second
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // register both stages
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : etls_sync
`default_nettype wire
